// ### verilog/isa_consts.vh
// Constants of the I2C slave address and transfer block
// How it works
// - Data/address flag shows last byte kind
// - Stop flag set on STOP, cleared otherwise
// - Start flag set on START, cleared otherwise
// - Read/write bit from last match, until next condition
// - Buffer-full set when received byte completes
// - Header 11110 carries A9:A8, sent as write
// - High address byte sets interrupt, full, update
// - Low address write clears update, frees clock
// - High address restore clears update, frees clock
// - Repeated header read sets interrupt, full and read/write, not update
// - Write match clears read/write, loads buffer
// - No acknowledge while full or overflow set
// - Copy and ACK only when both clear
// - Interrupt flag per byte, software clears
// - Read match sets read/write, ACKs, holds clock
// - Buffer write loads shifter; release bit frees clock
// - Transmit bits change on clock falling edges
// - Transmit interrupt on ninth falling edge
// - Master acknowledge latched on ninth rising edge
// - Master no-ACK resets slave and status
// - Master ACK keeps clock held for data
`ifndef ISA_CONSTS_VH
`define ISA_CONSTS_VH

// Register offsets
`define ISA_OFF_STAT  8'h94
`define ISA_OFF_BUF   8'h13
`define ISA_OFF_CTRL  8'h14
`define ISA_OFF_ADDR  8'h93
`define ISA_OFF_FLAG  8'h0c

// Status register fields
`define ISA_ST_SMP    7
`define ISA_ST_CKE    6
`define ISA_ST_DA     5
`define ISA_ST_P      4
`define ISA_ST_S      3
`define ISA_ST_RW     2
`define ISA_ST_UA     1
`define ISA_ST_BF     0

// Control register fields
`define ISA_CT_OV     6
`define ISA_CT_EN     5
`define ISA_CT_CKP    4
`define ISA_CT_TEN    0

// Flag register field
`define ISA_FL_PIF    3

// Reset values
`define ISA_RST_BYTE  8'h00

// Ten-bit header prefix
`define ISA_HDR_PFX   5'h1e

// Bit counts within one byte frame
`define ISA_CNT_BYTE  4'h8
`define ISA_CNT_ACK   4'h9

`endif

// ### verilog/isa_slave.v
// I2C slave: status flags, 7/10-bit address, receive and transmit
`timescale 1ns/1ps
`default_nettype none
`include "isa_consts.vh"

module isa_slave
(
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       scl_in,
	output reg        scl_out,
	output reg        scl_oe,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	output reg        port_interrupt_flag
);

	// Frame phases
	localparam [2:0] PH_IDLE = 3'h0;
	localparam [2:0] PH_ADR1 = 3'h1;
	localparam [2:0] PH_ADR2 = 3'h2;
	localparam [2:0] PH_RXD  = 3'h3;
	localparam [2:0] PH_TXD  = 3'h4;

	// Pin synchronisers and previous samples
	reg       scl_m_r, scl_s_r, scl_d_r;
	reg       sda_m_r, sda_s_r, sda_d_r;

	// Status and control state
	reg       smp_r, cke_r;
	reg       da_r;
	reg       stop_r;
	reg       start_r;
	reg       rw_r;
	reg       ua_r;
	reg       bf_r;
	reg       ov_r, en_r, ckp_r, ten_r;
	reg [7:0] buf_r;
	reg [7:0] addr_r;
	reg [7:0] shift_r;

	// Frame engine state
	reg [2:0] phase_r;
	reg [3:0] cnt_r;
	reg       mack_r, hold_nxt_r, tx_wait_r, lowok_r;

	// Edges on the synchronised lines only
	wire scl_rise  = scl_s_r & ~scl_d_r;
	wire scl_fall  = ~scl_s_r & scl_d_r;
	wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire bus_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// Acceptance only when nothing unread or overflowed
	wire rx_ok    = ~bf_r & ~ov_r;
	wire hdr_byte = (shift_r[7:3] == `ISA_HDR_PFX);
	wire match7   = (shift_r[7:1] == addr_r[7:1]);

	// Read data multiplexer, unmapped offsets read zero
	function [7:0] rd_mux;
		input [7:0] a;
		begin
			case (a)
				`ISA_OFF_STAT: rd_mux = {smp_r, cke_r, da_r, stop_r,
					start_r, rw_r, ua_r, bf_r};
				`ISA_OFF_BUF:  rd_mux = buf_r;
				`ISA_OFF_CTRL: rd_mux = {1'b0, ov_r, en_r, ckp_r,
					3'b000, ten_r};
				`ISA_OFF_ADDR: rd_mux = addr_r;
				`ISA_OFF_FLAG: rd_mux = {4'h0, port_interrupt_flag, 3'b000};
				default:       rd_mux = `ISA_RST_BYTE;
			endcase
		end
	endfunction

	// Whole block; software side first so hardware sets win
	always @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata           <= `ISA_RST_BYTE;
			scl_out             <= 1'b0;
			scl_oe              <= 1'b0;
			sda_out             <= 1'b0;
			sda_oe              <= 1'b0;
			port_interrupt_flag <= 1'b0;
			scl_m_r             <= 1'b1;
			scl_s_r             <= 1'b1;
			scl_d_r             <= 1'b1;
			sda_m_r             <= 1'b1;
			sda_s_r             <= 1'b1;
			sda_d_r             <= 1'b1;
			smp_r               <= 1'b0;
			cke_r               <= 1'b0;
			da_r                <= 1'b0;
			stop_r              <= 1'b0;
			start_r             <= 1'b0;
			rw_r                <= 1'b0;
			ua_r                <= 1'b0;
			bf_r                <= 1'b0;
			ov_r                <= 1'b0;
			en_r                <= 1'b0;
			ckp_r               <= 1'b0;
			ten_r               <= 1'b0;
			buf_r               <= `ISA_RST_BYTE;
			addr_r              <= `ISA_RST_BYTE;
			shift_r             <= `ISA_RST_BYTE;
			phase_r             <= PH_IDLE;
			cnt_r               <= 4'h0;
			mack_r              <= 1'b1;
			hold_nxt_r          <= 1'b0;
			tx_wait_r           <= 1'b0;
			lowok_r             <= 1'b0;
		end
		else if (ce)
		begin
			// Two-stage synchronisers, third stage for edges
			scl_m_r <= scl_in;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
			// Read data stands one cycle only
			reg_rdata <= `ISA_RST_BYTE;
			if (reg_rd)
			begin
				reg_rdata <= rd_mux(reg_addr);
				if (reg_addr == `ISA_OFF_BUF)
					bf_r <= 1'b0;
			end
			// Register writes
			if (reg_wr)
			begin
				case (reg_addr)
					`ISA_OFF_STAT:
					begin
						smp_r <= reg_wdata[`ISA_ST_SMP];
						cke_r <= reg_wdata[`ISA_ST_CKE];
					end
					`ISA_OFF_BUF:
					begin
						buf_r <= reg_wdata;
						if (phase_r == PH_TXD)
						begin
							shift_r <= reg_wdata;
							bf_r    <= 1'b1;
							// First bit goes out while SCL is still held low
							if (tx_wait_r)
								sda_oe <= ~reg_wdata[7];
						end
					end
					`ISA_OFF_CTRL:
					begin
						// Overflow can only be cleared by software
						ov_r  <= ov_r & reg_wdata[`ISA_CT_OV];
						en_r  <= reg_wdata[`ISA_CT_EN];
						ckp_r <= reg_wdata[`ISA_CT_CKP];
						ten_r <= reg_wdata[`ISA_CT_TEN];
					end
					`ISA_OFF_ADDR:
					begin
						addr_r <= reg_wdata;
						if (ua_r)
						begin
							ua_r   <= 1'b0;
							scl_oe <= 1'b0;
						end
					end
					`ISA_OFF_FLAG:
						port_interrupt_flag <= port_interrupt_flag &
							reg_wdata[`ISA_FL_PIF];
					default:
						smp_r <= smp_r;
				endcase
			end
			// Release bit frees the clock; bit 7 already stands, so no SDA move in SCL high
			if (tx_wait_r && ckp_r)
			begin
				tx_wait_r <= 1'b0;
				scl_oe    <= 1'b0;
				shift_r   <= {shift_r[6:0], 1'b0};
			end
			// Bus conditions and the frame engine
			if (!en_r)
			begin
				stop_r    <= 1'b0;
				start_r   <= 1'b0;
				phase_r   <= PH_IDLE;
				cnt_r     <= 4'h0;
				sda_oe    <= 1'b0;
				scl_oe    <= 1'b0;
				tx_wait_r <= 1'b0;
				lowok_r   <= 1'b0;
			end
			else if (bus_start)
			begin
				start_r    <= 1'b1;
				stop_r     <= 1'b0;
				rw_r       <= 1'b0;
				phase_r    <= PH_ADR1;
				cnt_r      <= 4'h0;
				sda_oe     <= 1'b0;
				hold_nxt_r <= 1'b0;
				tx_wait_r  <= 1'b0;
			end
			else if (bus_stop)
			begin
				stop_r    <= 1'b1;
				start_r   <= 1'b0;
				rw_r      <= 1'b0;
				phase_r   <= PH_IDLE;
				cnt_r     <= 4'h0;
				sda_oe    <= 1'b0;
				scl_oe    <= 1'b0;
				tx_wait_r <= 1'b0;
				lowok_r   <= 1'b0;
			end
			else if (phase_r != PH_IDLE)
			begin
				// Rising edges: sample data bits or master acknowledge
				if (scl_rise)
				begin
					if (cnt_r < `ISA_CNT_BYTE)
					begin
						cnt_r <= cnt_r + 4'h1;
						if (phase_r != PH_TXD)
							shift_r <= {shift_r[6:0], sda_s_r};
					end
					else if (cnt_r == `ISA_CNT_ACK && phase_r == PH_TXD)
						mack_r <= sda_s_r;
				end
				// Falling edges: drive bits, decide bytes, end ack slot
				if (scl_fall)
				begin
					if (cnt_r == `ISA_CNT_BYTE)
					begin
						cnt_r <= `ISA_CNT_ACK;
						case (phase_r)
							PH_ADR1:
							begin
								if (ten_r && match7 && hdr_byte && !shift_r[0])
								begin
									// High byte of a ten-bit write
									da_r                <= 1'b0;
									rw_r                <= 1'b0;
									ua_r                <= 1'b1;
									port_interrupt_flag <= 1'b1;
									hold_nxt_r          <= 1'b1;
									phase_r             <= PH_ADR2;
									if (rx_ok)
									begin
										buf_r  <= shift_r;
										bf_r   <= 1'b1;
										sda_oe <= 1'b1;
									end
									else if (bf_r)
										ov_r <= 1'b1;
								end
								else if (ten_r && match7 && hdr_byte && lowok_r)
								begin
									// Repeated header for a read, no update
									da_r                <= 1'b0;
									rw_r                <= 1'b1;
									port_interrupt_flag <= 1'b1;
									hold_nxt_r          <= 1'b1;
									phase_r             <= PH_TXD;
									if (rx_ok)
									begin
										buf_r  <= shift_r;
										bf_r   <= 1'b1;
										sda_oe <= 1'b1;
									end
									else if (bf_r)
										ov_r <= 1'b1;
								end
								else if (!ten_r && match7)
								begin
									da_r                <= 1'b0;
									rw_r                <= shift_r[0];
									port_interrupt_flag <= 1'b1;
									hold_nxt_r          <= shift_r[0];
									phase_r             <= shift_r[0] ? PH_TXD : PH_RXD;
									if (rx_ok)
									begin
										buf_r  <= shift_r;
										bf_r   <= 1'b1;
										sda_oe <= 1'b1;
									end
									else if (bf_r)
										ov_r <= 1'b1;
								end
								else
									phase_r <= PH_IDLE;
							end
							PH_ADR2:
							begin
								if (shift_r == addr_r)
								begin
									// Low byte matched; software restores high byte
									lowok_r             <= 1'b1;
									da_r                <= 1'b0;
									ua_r                <= 1'b1;
									port_interrupt_flag <= 1'b1;
									hold_nxt_r          <= 1'b1;
									phase_r             <= PH_RXD;
									if (rx_ok)
									begin
										buf_r  <= shift_r;
										bf_r   <= 1'b1;
										sda_oe <= 1'b1;
									end
									else if (bf_r)
										ov_r <= 1'b1;
								end
								else
									phase_r <= PH_IDLE;
							end
							PH_RXD:
							begin
								da_r                <= 1'b1;
								port_interrupt_flag <= 1'b1;
								if (rx_ok)
								begin
									buf_r  <= shift_r;
									bf_r   <= 1'b1;
									sda_oe <= 1'b1;
								end
								else if (bf_r)
									ov_r <= 1'b1;
							end
							PH_TXD:
							begin
								// Free the data line for the master acknowledge
								da_r   <= 1'b1;
								bf_r   <= 1'b0;
								sda_oe <= 1'b0;
							end
							default:
								phase_r <= PH_IDLE;
						endcase
					end
					else if (cnt_r == `ISA_CNT_ACK)
					begin
						cnt_r  <= 4'h0;
						sda_oe <= 1'b0;
						if (hold_nxt_r)
						begin
							// Stretch until software answers
							hold_nxt_r <= 1'b0;
							scl_oe     <= 1'b1;
							if (phase_r == PH_TXD)
							begin
								tx_wait_r <= 1'b1;
								ckp_r     <= 1'b0;
							end
						end
						else if (phase_r == PH_TXD)
						begin
							port_interrupt_flag <= 1'b1;
							if (mack_r)
							begin
								// No acknowledge: back to waiting for START
								phase_r <= PH_IDLE;
								start_r <= 1'b0;
								da_r    <= 1'b0;
								rw_r    <= 1'b0;
								ua_r    <= 1'b0;
								bf_r    <= 1'b0;
							end
							else
							begin
								scl_oe    <= 1'b1;
								tx_wait_r <= 1'b1;
								ckp_r     <= 1'b0;
							end
						end
					end
					else if (phase_r == PH_TXD && cnt_r != 4'h0)
					begin
						sda_oe  <= ~shift_r[7];
						shift_r <= {shift_r[6:0], 1'b0};
					end
				end
			end
		end
	end

endmodule // isa_slave

`default_nettype wire

// ### tb/isa_slave_checker.sv
// Port-level assertions for the I2C slave block
`timescale 1ns/1ps
`default_nettype none
module isa_slave_checker (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       port_interrupt_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// A driven SDA level lasts a good part of an SCL phase
	sequence sda_hold_s;
		$stable(sda_oe) [*4];
	endsequence
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	drain_only_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("open-drain pin driven high");
	// Stretch ends only through a register write
	stretch_hold_a: assert property (scl_oe && !reg_wr && !$past(reg_wr) |=> scl_oe)
		else $error("clock stretch ended without write");
	stretch_start_a: assert property ($rose(scl_oe) |-> !$past(scl_in))
		else $error("clock stretch began while SCL high");
	flag_rise_a: assert property ($rose(port_interrupt_flag) |-> !scl_in)
		else $error("byte flag set outside SCL low");
	flag_clear_a: assert property ($fell(port_interrupt_flag) |-> $past(reg_wr))
		else $error("byte flag cleared without write");
	sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("SDA moved while SCL high");
	sda_hold_a: assert property ($changed(sda_oe) |=> sda_hold_s)
		else $error("SDA level held too briefly");
endmodule // isa_slave_checker
bind isa_slave isa_slave_checker chk (.clk(clk), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
	.port_interrupt_flag(port_interrupt_flag));
`default_nettype wire

// ### tb/isa_master.sv
// Behavioural I2C bus master on an open-drain pair
`timescale 1ns/1ps
`default_nettype none
module isa_master (
	input  wire logic scl_w,
	input  wire logic sda_w,
	output var  logic scl_m,
	output var  logic sda_m
);
	// Released lines idle high through pull-ups
	initial
	begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// Data set while SCL low, line read mid high phase
	task automatic put_bit(input logic b, output logic r);
		sda_m = b;
		#62.5;
		scl_m = 1'b1;
		wait (scl_w === 1'b1); // Look at SCL before each pulse
		#31.25;
		r = sda_w;
		#31.25;
		scl_m = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic n, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], q[i]);
		put_bit(n, a);
	endtask
	// Plain or repeated START; callers then send the address byte, R/W low or high, through xfer
	task automatic start_c;
		sda_m = 1'b1;
		#62.5;
		scl_m = 1'b1;
		wait (scl_w === 1'b1);
		#62.5;
		sda_m = 1'b0;
		#62.5;
		scl_m = 1'b0;
	endtask
	task automatic stop_c;
		sda_m = 1'b0;
		#62.5;
		scl_m = 1'b1;
		wait (scl_w === 1'b1);
		#62.5;
		sda_m = 1'b1;
		#62.5;
	endtask
endmodule // isa_master
`default_nettype wire

// ### tb/isa_slave_bench.sv
// Self-checking bench for the I2C slave block
`timescale 1ns/1ps
`default_nettype none
`include "isa_consts.vh"
module isa_slave_bench;
	localparam logic [7:0] ST = `ISA_OFF_STAT, BU = `ISA_OFF_BUF, CT = `ISA_OFF_CTRL;
	localparam logic [7:0] AD = `ISA_OFF_ADDR, FL = `ISA_OFF_FLAG;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	wire  [7:0] reg_rdata;
	wire        scl_out, scl_oe, sda_out, sda_oe, pif, scl_m, sda_m;
	wire        scl_w = scl_m & ~scl_oe;
	wire        sda_w = sda_m & ~sda_oe;
	int         err_total = 0;
	int         n_checks = 0;
	int         seed = 56;
	logic [7:0] v, q, ctl, hdr, lo;
	logic [6:0] adr;
	logic       ack;
	always #2.5 clk = ~clk;
	isa_slave dut (.clk(clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .port_interrupt_flag(pif));
	isa_master mst (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
	function automatic logic [7:0] st(input logic d, p, s, w, u, b);
		return {2'b00, d, p, s, w, u, b};
	endfunction
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Leading gap lets synchronised bus events land first
	task automatic rc(input logic [7:0] a, e, input string s);
		repeat (6) @(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		chk(s, e, v);
	endtask
	task automatic chk(input string s, input logic [7:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Slave sends one byte once software loads it and frees SCL
	task automatic tx(input logic [7:0] d, input logic n);
		fork
			mst.xfer(8'hff, n, q, ack);
			begin
				wait (scl_oe === 1'b1);
				wr(BU, d);
				wr(CT, ctl | 8'h10);
			end
		join
		chk("tx", d, q);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Guard against a bus that never completes
	initial
	begin
		#300000;
		err_total++;
		final_report;
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		adr = {2'b01, 5'($random(seed))};
		rc(ST, 8'h00, "st rst");
		rc(8'h55, 8'h00, "unmapped");
		ctl = 8'h20;
		wr(CT, ctl);
		wr(AD, {adr, 1'b0});
		mst.start_c;
		mst.xfer({~adr, 1'b0}, 1'b1, q, ack);
		chk("miss", 8'h01, {7'h0, ack});
		mst.stop_c;
		mst.start_c;
		mst.xfer({adr, 1'b0}, 1'b1, q, ack);
		chk("ack", 8'h00, {7'h0, ack});
		rc(ST, st(0, 0, 1, 0, 0, 1), "st wa");
		rc(BU, {adr, 1'b0}, "buf wa");
		rc(FL, 8'h08, "flag");
		chk("flag pin", 8'h01, {7'h0, pif});
		wr(FL, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			lo = 8'($random(seed));
			mst.xfer(lo, 1'b1, q, ack);
			rc(ST, st(1, 0, 1, 0, 0, 1), "st dat");
			rc(BU, lo, "buf dat");
		end
		// Unread byte then overflow: no ACK, buffer kept
		mst.xfer(8'h5a, 1'b1, q, ack);
		mst.xfer(8'ha5, 1'b1, q, ack);
		chk("full", 8'h01, {7'h0, ack});
		rc(CT, 8'h60, "ov");
		rc(BU, 8'h5a, "kept");
		wr(FL, 8'h00);
		mst.xfer(8'h3c, 1'b1, q, ack);
		chk("ov nak", 8'h01, {7'h0, ack});
		rc(FL, 8'h08, "flag ov");
		wr(CT, ctl);
		mst.stop_c;
		rc(ST, st(1, 1, 0, 0, 0, 0), "st stop");
		mst.start_c;
		mst.xfer({adr, 1'b1}, 1'b1, q, ack);
		chk("rd ack", 8'h00, {7'h0, ack});
		rc(ST, st(0, 0, 1, 1, 0, 1), "st ra");
		rc(BU, {adr, 1'b1}, "buf ra");
		chk("hold", 8'h01, {7'h0, scl_oe});
		wr(FL, 8'h00);
		tx(8'($random(seed)), 1'b0);
		rc(FL, 8'h08, "tx flag");
		repeat (20) @(posedge clk);
		chk("ack hold", 8'h01, {7'h0, scl_oe});
		tx(8'($random(seed)), 1'b1);
		rc(ST, 8'h00, "nak");
		mst.stop_c;
		// Ten-bit address, then a repeated START for transmit
		ctl = 8'h21;
		wr(CT, ctl);
		hdr = {5'h1e, 2'($random(seed)), 1'b0};
		lo = 8'($random(seed));
		wr(AD, hdr);
		mst.start_c;
		mst.xfer(hdr, 1'b1, q, ack);
		chk("hdr ack", 8'h00, {7'h0, ack});
		rc(ST, st(0, 0, 1, 0, 1, 1), "st hdr");
		rc(BU, hdr, "buf hdr");
		wr(AD, lo);
		rc(ST, st(0, 0, 1, 0, 0, 0), "ua lo");
		chk("free", 8'h00, {7'h0, scl_oe});
		mst.xfer(lo, 1'b1, q, ack);
		chk("lo ack", 8'h00, {7'h0, ack});
		rc(ST, st(0, 0, 1, 0, 1, 1), "st lo");
		rc(BU, lo, "buf lo");
		wr(AD, hdr);
		rc(ST, st(0, 0, 1, 0, 0, 0), "ua hi");
		mst.start_c;
		mst.xfer(hdr | 8'h01, 1'b1, q, ack);
		chk("rpt ack", 8'h00, {7'h0, ack});
		rc(ST, st(0, 0, 1, 1, 0, 1), "st rpt");
		tx(8'($random(seed)), 1'b1);
		mst.stop_c;
		wr(CT, 8'h00);
		rc(ST, 8'h00, "st off");
		final_report;
	end
endmodule // isa_slave_bench
`default_nettype wire
